//--- hdl/rx_sync_pkg.sv
// Constants, register map and carrier types for the receive estimator and bit synchronizer
package rx_sync_pkg;

  localparam logic [6:0] ADDR_FRONT_END   = 7'h00;
  localparam logic [6:0] ADDR_MOD_FILTER  = 7'h01;
  localparam logic [6:0] ADDR_CLK_SHIFT   = 7'h06;
  localparam logic [6:0] ADDR_RATE_PRESC  = 7'h07;
  localparam logic [6:0] ADDR_FEE_CTRL    = 7'h15;
  localparam logic [6:0] ADDR_FEE_RESULT  = 7'h16;

  localparam logic [7:0] RST_REG          = 8'h00;

  // Field positions
  localparam int SYNC_EN_BIT    = 3;
  localparam int MODE_LSB       = 1;
  localparam int MOD_SHIFT_LSB  = 4;
  localparam int SYNC_SHIFT_LSB = 1;
  localparam int TX_S2_BIT      = 0;
  localparam int TX_S10_LSB     = 6;
  localparam int PRESC_LSB      = 0;
  localparam int EST_MODE_LSB   = 0;
  localparam int WINDOW_LSB     = 2;

  localparam logic [1:0] MODE_RX        = 2'h2;
  localparam logic [1:0] EST_OFF        = 2'h0;
  localparam logic [1:0] EST_UP         = 2'h1;
  localparam logic [1:0] EST_DN         = 2'h2;
  localparam logic [1:0] EST_BOTH       = 2'h3;

  localparam logic [6:0] WINDOW_BASE    = 7'h08;
  localparam logic [3:0] SYNC_OVERSAMP  = 4'hf;
  localparam logic [3:0] PHASE_CENTER   = 4'h8;
  localparam logic [7:0] CNT_MAX        = 8'h7f;
  localparam logic [7:0] CNT_MIN        = 8'h80;
  localparam logic [2:0] SHIFT_TOP      = 3'h7;
  localparam logic [4:0] FRAME_ADDR_END = 5'h08;
  localparam logic [4:0] FRAME_END      = 5'h10;
  localparam int         NUM_DIV        = 3;

  typedef struct packed {
    logic       sync_en;
    logic [1:0] mode;
    logic [2:0] mod_shift;
    logic [2:0] sync_shift;
    logic [2:0] tx_shift;
    logic [5:0] prescaler;
    logic [1:0] est_mode;
    logic [1:0] window;
  } cfg_s;

  typedef struct packed {
    logic       clk;
    logic       sel;
    logic       din;
  } prog_pins_s;

endpackage

//--- hdl/rx_freq_error_and_bit_sync.sv
// Frequency error estimator, bit synchronizer, shared prescaler and serial programming port
`timescale 1ns/100ps

// Contract
// - Estimator inputs are demodulator up pulses for ones and down pulses for zeros.
// - Mode field: 00 off, 01 up only, 10 down only, 11 both.
// - Combined mode: up increments, down decrements the counter.
// - Window field selects 8, 16, 32 or 64 symbols.
// - Result readable as eight bits at the result register address.
// - Negative results are stored in two's complement.
// - Only down-only and combined modes can give negative results.
// - Synchronizer runs only in receive mode with sync enable set; drives clock pin.
// - Recovered clock runs at the bit rate, as the numeric example shows.
// - Each received bit changes on the data pin at recovered clock rise.
// - Synchronizer clock is programmed to sixteen times the bit rate.
// - Sync clock is reference over prescaler times two to (7 minus shift).
// - One prescaler also feeds modulator and transmit rate dividers.
// - Synchronizer locks within 22 bits from worst initial phase.
// - Registers are written and read over a three-wire serial port.
module rx_freq_error_and_bit_sync
  import rx_sync_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic ce_i,
  input  wire logic prog_clk_i,
  input  wire logic prog_sel_i,
  input  wire logic prog_data_i,
  output logic      prog_data_o,
  output logic      prog_data_oe_o,
  input  wire logic demod_data_i,
  input  wire logic up_pulse_i,
  input  wire logic dn_pulse_i,
  output logic      recovered_clock_pin_o,
  output logic      data_io_pin_o,
  output logic      data_io_pin_oe_o,
  output logic      mod_clk_tick_o,
  output logic      tx_rate_tick_o
);

  logic [7:0] reg_front_ff, reg_modf_ff, reg_shift_ff, reg_presc_ff, reg_fee_ctrl_ff;
  logic [7:0] fee_result_ff;
  cfg_s       cfg;

  // Serial port: pins pass two flip-flops, edges seen between stage two and three
  prog_pins_s meta_ff, sync_ff, last_ff;
  logic       prog_rise, prog_fall;
  logic [4:0] bit_cnt_ff;
  logic [7:0] addr_sh_ff;
  logic [7:0] data_sh_ff;
  logic [7:0] out_sh_ff;
  logic       rd_oe_ff;
  logic       wr_stb;
  logic [7:0] rd_data;

  assign prog_rise = sync_ff.clk & ~last_ff.clk;
  assign prog_fall = ~sync_ff.clk & last_ff.clk;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_ff <= '0;
      sync_ff <= '0;
      last_ff <= '0;
    end else if (ce_i) begin
      meta_ff <= '{clk: prog_clk_i, sel: prog_sel_i, din: prog_data_i};
      sync_ff <= meta_ff;
      last_ff <= sync_ff;
    end
  end

  // Frame: read flag and seven address bits, then eight data bits, MSB first
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bit_cnt_ff <= '0;
      addr_sh_ff <= '0;
      data_sh_ff <= '0;
    end else if (ce_i) begin
      if (!sync_ff.sel) begin
        bit_cnt_ff <= '0;
      end else if (prog_rise && bit_cnt_ff != FRAME_END) begin
        bit_cnt_ff <= bit_cnt_ff + 5'h01;
        if (bit_cnt_ff < FRAME_ADDR_END) begin
          addr_sh_ff <= {addr_sh_ff[6:0], sync_ff.din};
        end else begin
          data_sh_ff <= {data_sh_ff[6:0], sync_ff.din};
        end
      end
    end
  end

  assign wr_stb = sync_ff.sel && prog_rise && bit_cnt_ff == FRAME_END - 5'h01 && !addr_sh_ff[7];

  always_comb begin
    case ({addr_sh_ff[5:0], sync_ff.din})
      ADDR_FRONT_END:  rd_data = reg_front_ff;
      ADDR_MOD_FILTER: rd_data = reg_modf_ff;
      ADDR_CLK_SHIFT:  rd_data = reg_shift_ff;
      ADDR_RATE_PRESC: rd_data = reg_presc_ff;
      ADDR_FEE_CTRL:   rd_data = {4'h0, reg_fee_ctrl_ff[3:0]};
      ADDR_FEE_RESULT: rd_data = fee_result_ff;
      default:         rd_data = 8'h00;
    endcase
  end

  // Read data loads as the last address bit arrives and shifts on each falling edge after the first data bit
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      out_sh_ff <= '0;
      rd_oe_ff  <= 1'b0;
    end else if (ce_i) begin
      if (!sync_ff.sel) begin
        rd_oe_ff <= 1'b0;
      end else if (prog_rise && bit_cnt_ff == FRAME_ADDR_END - 5'h01) begin
        out_sh_ff <= rd_data;
        rd_oe_ff  <= addr_sh_ff[6];
      end else if (prog_fall && rd_oe_ff && bit_cnt_ff > FRAME_ADDR_END) begin
        out_sh_ff <= {out_sh_ff[6:0], 1'b0};
      end
    end
  end

  assign prog_data_o    = out_sh_ff[7];
  assign prog_data_oe_o = rd_oe_ff;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reg_front_ff    <= RST_REG;
      reg_modf_ff     <= RST_REG;
      reg_shift_ff    <= RST_REG;
      reg_presc_ff    <= RST_REG;
      reg_fee_ctrl_ff <= RST_REG;
    end else if (ce_i && wr_stb) begin
      case (addr_sh_ff[6:0])
        ADDR_FRONT_END:  reg_front_ff    <= {data_sh_ff[6:0], sync_ff.din};
        ADDR_MOD_FILTER: reg_modf_ff     <= {data_sh_ff[6:0], sync_ff.din};
        ADDR_CLK_SHIFT:  reg_shift_ff    <= {data_sh_ff[6:0], sync_ff.din};
        ADDR_RATE_PRESC: reg_presc_ff    <= {data_sh_ff[6:0], sync_ff.din};
        ADDR_FEE_CTRL:   reg_fee_ctrl_ff <= {4'h0, data_sh_ff[2:0], sync_ff.din};
        default:         reg_front_ff    <= reg_front_ff;
      endcase
    end
  end

  assign cfg = '{sync_en:    reg_front_ff[SYNC_EN_BIT],
                 mode:       reg_front_ff[MODE_LSB +: 2],
                 mod_shift:  reg_shift_ff[MOD_SHIFT_LSB +: 3],
                 sync_shift: reg_shift_ff[SYNC_SHIFT_LSB +: 3],
                 tx_shift:   {reg_shift_ff[TX_S2_BIT], reg_presc_ff[TX_S10_LSB +: 2]},
                 prescaler:  reg_presc_ff[PRESC_LSB +: 6],
                 est_mode:   reg_fee_ctrl_ff[EST_MODE_LSB +: 2],
                 window:     reg_fee_ctrl_ff[WINDOW_LSB +: 2]};

  // Shared prescaler; a setting of zero acts as one
  logic [5:0] pre_cnt_ff;
  logic       ref_tick;
  logic [2:0] div_shift [NUM_DIV];
  logic       div_tick  [NUM_DIV];
  logic       sync_tick;

  assign ref_tick = (pre_cnt_ff + 6'h01 >= cfg.prescaler);

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pre_cnt_ff <= '0;
    end else if (ce_i) begin
      pre_cnt_ff <= ref_tick ? 6'h00 : pre_cnt_ff + 6'h01;
    end
  end

  assign div_shift[0] = cfg.sync_shift;
  assign div_shift[1] = cfg.mod_shift;
  assign div_shift[2] = cfg.tx_shift;

  // Three power-of-two dividers all fed by the one prescaler
  for (genvar d = 0; d < NUM_DIV; d++) begin : g_div
    logic [6:0] cnt_ff;
    logic [6:0] limit;
    assign limit       = 7'((8'h01 << (SHIFT_TOP - div_shift[d])) - 8'h01);
    assign div_tick[d] = ref_tick && cnt_ff >= limit;
    always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        cnt_ff <= '0;
      end else if (ce_i && ref_tick) begin
        cnt_ff <= div_tick[d] ? 7'h00 : cnt_ff + 7'h01;
      end
    end
  end

  assign sync_tick      = div_tick[0];
  assign mod_clk_tick_o = div_tick[1];
  assign tx_rate_tick_o = div_tick[2];

  // Bit synchronizer: sixteen samples a bit, edges nudge phase toward zero
  logic       sync_active;
  logic [3:0] phase_ff;
  logic [3:0] nxt_phase;
  logic       samp_ff;
  logic       rclk_ff;
  logic       data_out_ff;
  logic       sym_tick;

  assign sync_active = cfg.sync_en && cfg.mode == MODE_RX;

  always_comb begin
    nxt_phase = phase_ff + 4'h1;
    if (demod_data_i != samp_ff && phase_ff != 4'h0) begin
      nxt_phase = phase_ff < PHASE_CENTER ? phase_ff : 4'(phase_ff + 4'h2);
    end
  end

  assign sym_tick = sync_active && sync_tick && nxt_phase[3] && !rclk_ff;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      phase_ff <= '0;
      samp_ff  <= 1'b0;
      rclk_ff  <= 1'b0;
    end else if (ce_i) begin
      if (!sync_active) begin
        phase_ff <= '0;
        rclk_ff  <= 1'b0;
      end else if (sync_tick) begin
        phase_ff <= nxt_phase;
        samp_ff  <= demod_data_i;
        rclk_ff  <= nxt_phase[3];
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      data_out_ff <= 1'b0;
    end else if (ce_i) begin
      if (!sync_active) begin
        data_out_ff <= demod_data_i;
      end else if (sym_tick) begin
        data_out_ff <= samp_ff;
      end
    end
  end

  assign recovered_clock_pin_o = rclk_ff;
  assign data_io_pin_o         = data_out_ff;
  assign data_io_pin_oe_o      = cfg.mode == MODE_RX;

  // Frequency error estimator; a pulse on the closing cycle opens the next window
  logic [7:0] fee_cnt_ff;
  logic [6:0] sym_cnt_ff;
  logic [6:0] window_len;
  logic       win_done;
  logic       do_inc;
  logic       do_dec;

  assign window_len = WINDOW_BASE << cfg.window;
  assign win_done   = sym_tick && sym_cnt_ff + 7'h01 >= window_len;
  assign do_inc     = up_pulse_i && cfg.est_mode[0] && !(cfg.est_mode == EST_BOTH && dn_pulse_i);
  assign do_dec     = dn_pulse_i && cfg.est_mode[1] && !(cfg.est_mode == EST_BOTH && up_pulse_i);

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fee_cnt_ff <= '0;
      sym_cnt_ff <= '0;
    end else if (ce_i) begin
      if (cfg.est_mode == EST_OFF || win_done) begin
        fee_cnt_ff <= do_inc ? 8'h01 : do_dec ? 8'hff : 8'h00;
        sym_cnt_ff <= '0;
      end else begin
        if (sym_tick) begin
          sym_cnt_ff <= sym_cnt_ff + 7'h01;
        end
        if (do_inc && fee_cnt_ff != CNT_MAX) begin
          fee_cnt_ff <= fee_cnt_ff + 8'h01;
        end else if (do_dec && fee_cnt_ff != CNT_MIN) begin
          fee_cnt_ff <= fee_cnt_ff - 8'h01;
        end
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fee_result_ff <= '0;
    end else if (ce_i && win_done && cfg.est_mode != EST_OFF) begin
      fee_result_ff <= fee_cnt_ff;
    end
  end

  sequence s_up_only_step;
    ce_i && cfg.est_mode == EST_UP && !win_done;
  endsequence

  sequence s_window_close;
    ce_i && win_done && cfg.est_mode != EST_OFF;
  endsequence

  chk_up_never_down: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    s_up_only_step |=> fee_cnt_ff >= $past(fee_cnt_ff))
    else $error("Up-only count decreased");

  chk_both_inc_step: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ce_i && cfg.est_mode == EST_BOTH && up_pulse_i && !dn_pulse_i && !win_done && fee_cnt_ff != CNT_MAX
    |=> fee_cnt_ff == $past(fee_cnt_ff) + 8'h01)
    else $error("Combined mode up pulse did not increment");

  chk_both_dec_step: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ce_i && cfg.est_mode == EST_BOTH && dn_pulse_i && !up_pulse_i && !win_done && fee_cnt_ff != CNT_MIN
    |=> fee_cnt_ff == $past(fee_cnt_ff) - 8'h01)
    else $error("Combined mode down pulse did not decrement");

  chk_off_mode_idle: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ce_i && cfg.est_mode == EST_OFF |=> fee_cnt_ff == 8'h00 && $stable(fee_result_ff))
    else $error("Estimator active while off");

  chk_result_latch: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    s_window_close |=> fee_result_ff == $past(fee_cnt_ff)
      && fee_cnt_ff == ($past(do_inc) ? 8'h01 : $past(do_dec) ? 8'hff : 8'h00))
    else $error("Window end did not latch result and clear count");

  chk_clock_gated: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ce_i && !sync_active |=> !recovered_clock_pin_o)
    else $error("Recovered clock running outside synchronous receive");

  chk_data_on_rise: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $past(sync_active) && sync_active && $changed(data_io_pin_o) |-> $rose(recovered_clock_pin_o))
    else $error("Received bit changed away from clock rise");

  chk_prescaler_gap: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ce_i && ref_tick && cfg.prescaler > 6'h01 ##1 ce_i && $stable(cfg.prescaler) |-> !ref_tick)
    else $error("Prescaler ticked on consecutive cycles");

  chk_reg_write: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ce_i && wr_stb && addr_sh_ff[6:0] == ADDR_FEE_CTRL
    |=> reg_fee_ctrl_ff[3:1] == $past(data_sh_ff[2:0]) && reg_fee_ctrl_ff[0] == $past(sync_ff.din))
    else $error("Serial write did not update control register");

endmodule

//--- testbench/host_rx_model.sv
// Host side model that samples received bits from the data pins
`timescale 1ns/100ps
module host_rx_model (
  input  wire logic       data_clk_i,
  input  wire logic       data_i,
  input  wire logic       data_oe_i,
  output logic      [7:0] bits_o
);
  initial bits_o = 8'h00;
  // One bit per recovered clock, taken on its falling edge; undriven pin reads unknown
  always @(negedge data_clk_i) begin
    bits_o <= {bits_o[6:0], (data_oe_i === 1'b1) ? data_i : 1'bx};
  end
endmodule

//--- testbench/rx_freq_error_and_bit_sync_tb.sv
// Self-checking bench for the estimator, bit synchronizer and serial register port
`timescale 1ns/100ps
module rx_freq_error_and_bit_sync_tb;
  import rx_sync_pkg::*;
  logic       clk_i = 1'b0, rst_n_i = 1'b0, ce_i = 1'b1;
  logic       prog_clk_i = 1'b0, prog_sel_i = 1'b0, prog_data_i = 1'b0;
  logic       demod_data_i = 1'b0, up_pulse_i = 1'b0, dn_pulse_i = 1'b0;
  logic       prog_data_o, prog_data_oe_o, recovered_clock_pin_o, data_io_pin_o, data_io_pin_oe_o;
  logic       mod_clk_tick_o, tx_rate_tick_o, run = 1'b0, sync_on = 1'b0, dq = 1'b0, cq = 1'b0;
  logic [1:0] pen = 2'h0;
  logic [7:0] host_bits, q;
  logic [9:0] ccnt = 10'h000;
  int         miscompares = 0, checks_done = 0;
  localparam logic [7:0] PAT = 8'h4d;
  // Scenario tables: front-end values, clock settings with periods, estimator settings with results
  logic [7:0] fe[3] = '{8'h04, 8'h0a, 8'h08};
  int         tb[4][3] = '{'{1, 7, 16}, '{1, 6, 32}, '{3, 7, 48}, '{2, 5, 128}};
  logic [7:0] est[7][2] = '{'{8'h00, 8'h00}, '{8'h01, 8'h20}, '{8'h02, 8'hf0}, '{8'h03, 8'h10},
                            '{8'h07, 8'h20}, '{8'h0d, 8'h7f}, '{8'h0e, 8'h80}};

  always #5 clk_i = ~clk_i;

  rx_freq_error_and_bit_sync i_rx_freq_error_and_bit_sync (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
    .prog_clk_i(prog_clk_i), .prog_sel_i(prog_sel_i), .prog_data_i(prog_data_i), .prog_data_o(prog_data_o),
    .prog_data_oe_o(prog_data_oe_o), .demod_data_i(demod_data_i), .up_pulse_i(up_pulse_i),
    .dn_pulse_i(dn_pulse_i), .recovered_clock_pin_o(recovered_clock_pin_o), .data_io_pin_o(data_io_pin_o),
    .data_io_pin_oe_o(data_io_pin_oe_o), .mod_clk_tick_o(mod_clk_tick_o), .tx_rate_tick_o(tx_rate_tick_o));

  host_rx_model i_host_rx_model (.data_clk_i(recovered_clock_pin_o), .data_i(data_io_pin_o),
    .data_oe_i(data_io_pin_oe_o), .bits_o(host_bits));

  // Received stream of 16 clocks per bit and periodic demodulator pulses
  always @(posedge clk_i) begin
    ccnt <= ccnt + 10'h001;
    if (run) demod_data_i <= PAT[~ccnt[6:4]];
    up_pulse_i <= pen[0] & (ccnt[1:0] == 2'h0);
    dn_pulse_i <= pen[1] & (ccnt[2:0] == 3'h0);
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  // While synchronized, the data pin may only move together with a clock rise
  always @(posedge clk_i) begin
    if (sync_on) chk({7'h0, data_io_pin_o === dq || (recovered_clock_pin_o === 1'b1 && cq === 1'b0)}, 8'h01,
                     "data edge");
    dq <= data_io_pin_o;
    cq <= recovered_clock_pin_o;
  end

  task automatic xfer(input logic rdn, input logic [6:0] a, input logic [7:0] wd, output logic [7:0] rdat);
    logic [15:0] f;
    f = {rdn, a, wd};
    rdat = 8'h00;
    @(posedge clk_i) prog_sel_i <= 1'b1;
    for (int i = 15; i >= 0; i--) begin
      repeat (8) @(posedge clk_i);
      prog_clk_i <= 1'b0;
      prog_data_i <= f[i];
      repeat (8) @(posedge clk_i);
      if (i < 8) rdat[i] = (prog_data_oe_o === 1'b1) ? prog_data_o : 1'bx;
      prog_clk_i <= 1'b1;
    end
    repeat (8) @(posedge clk_i);
    prog_clk_i <= 1'b0;
    prog_sel_i <= 1'b0;
    repeat (8) @(posedge clk_i);
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    xfer(1'b0, a, d, q);
  endtask

  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    xfer(1'b1, a, 8'h00, q);
    chk(q, e, "register read");
  endtask

  // Clocks between two rises of the chosen output
  task automatic gap(input int s, input int e);
    int   n, t0;
    logic p, v;
    n = 0;
    t0 = 0;
    p = 1'b1;
    for (int k = 0; k < 3000; k++) begin
      @(posedge clk_i);
      #1;
      v = (s == 0) ? recovered_clock_pin_o : (s == 1) ? tx_rate_tick_o : mod_clk_tick_o;
      if (v === 1'b1 && p === 1'b0) begin
        if (n == 1) begin
          chk(8'(k - t0), 8'(e), "period");
          break;
        end
        n = 1;
        t0 = k;
      end
      p = v;
    end
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge clk_i);
    miscompares++;
    $display("CHECK FAILED t=%0t watchdog expired", $time);
    close_out;
  end

  initial begin
    logic       hi, rot;
    repeat (16) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    rd(ADDR_FEE_CTRL, RST_REG);
    rd(ADDR_FEE_RESULT, RST_REG);
    wr(ADDR_FEE_CTRL, 8'hff);
    rd(ADDR_FEE_CTRL, 8'h0f);
    wr(ADDR_FEE_RESULT, 8'h5a);
    rd(ADDR_FEE_RESULT, 8'h00);
    wr(7'h03, 8'hff);
    rd(7'h03, 8'h00);
    wr(ADDR_FEE_CTRL, 8'h00);
    $display("test registers done");
    run = 1'b1;
    foreach (fe[i]) begin
      wr(ADDR_FRONT_END, fe[i]);
      hi = 1'b0;
      repeat (200) @(posedge clk_i) if (recovered_clock_pin_o !== 1'b0) hi = 1'b1;
      chk({7'h0, hi}, 8'h00, "clock while inactive");
    end
    run = 1'b0;
    $display("test sync gating done");
    wr(ADDR_FRONT_END, 8'h0c);
    foreach (tb[i]) begin
      wr(ADDR_CLK_SHIFT, {1'b0, 3'h6, 3'(tb[i][1]), 1'b1});
      wr(ADDR_RATE_PRESC, {2'b10, 6'(tb[i][0])});
      gap(0, tb[i][2]);
      gap(1, 2 * tb[i][0]);
      gap(2, 2 * tb[i][0]);
    end
    $display("test clock rates done");
    wr(ADDR_CLK_SHIFT, 8'h6f);
    wr(ADDR_RATE_PRESC, 8'h81);
    run = 1'b1;
    repeat (32 * 16) @(posedge clk_i);
    sync_on = 1'b1;
    rot = 1'b0;
    for (int r = 0; r < 8; r++) if (host_bits === 8'({PAT, PAT} >> r)) rot = 1'b1;
    chk({7'h0, rot}, 8'h01, "host received stream");
    $display("test lock done");
    pen = 2'h3;
    foreach (est[i]) begin
      wr(ADDR_FEE_CTRL, est[i][0]);
      repeat (3200) @(posedge clk_i);
      rd(ADDR_FEE_RESULT, est[i][1]);
    end
    $display("test estimator done");
    close_out;
  end
endmodule
